//--- dcp_channel_ctrl.sv
// channel enable, end flag, operation register and transfer strobe for four channels
// assumes a register master on core_clk and a bus-cycle unit that performs one unit per strobe
//
// The address map and strobed register access were chosen for this implementation.
`include "dcp_cfg.svh"

module dcp_channel_ctrl import dcp_pkg::*; (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdata,
    // request sources and events
    input  wire logic [3:0]  extReqN,
    input  wire logic [3:0]  periphReq,
    input  wire logic        nmiPin,
    input  wire logic        addrErr,
    input  wire logic        standbyEnter,
    // transfer and status outputs
    output logic             xferStrobe,
    output logic [1:0]       xferCh,
    output logic [3:0]       chanEnabled,
    output logic [3:0]       irqReq
);

    dcp_chmask_t chanEn_r, chanEn_nxt;
    dcp_chmask_t endFlag_r, endFlag_nxt;
    dcp_chmask_t irqEn_r, irqEn_nxt;
    dcp_chmask_t endArm_r, endArm_nxt;
    dcp_chmask_t pend_r, pend_nxt;
    logic [3:0]  reqSrc_r [4];
    logic [3:0]  reqSrc_nxt [4];
    logic [23:0] xferCnt_r [4];
    logic [23:0] xferCnt_nxt [4];
    dcp_prio_t   prio_r, prio_nxt;
    logic        masterEn_r, masterEn_nxt;
    logic        nmiFlag_r, nmiFlag_nxt;
    logic        aeFlag_r, aeFlag_nxt;
    logic        nmiArm_r, nmiArm_nxt;
    logic        aeArm_r, aeArm_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        strobe_r;
    logic [1:0]  strobeCh_r;
    dcp_chmask_t chanOk_r, irq_r;
    // synchronisers for pins
    logic [3:0]  extS1_r, extS2_r, extS3_r;
    logic        nmiS1_r, nmiS2_r, nmiS3_r;

    dcp_chmask_t chanOk, live, lastHit, extFall;
    logic        nmiRise;
    logic        ccsSel, cntSel, opSel;
    logic        gntValid;
    logic [1:0]  gntCh;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] chOf(input logic [7:0] a);
        chOf = a[3:2];
    endfunction

    assign ccsSel  = regAddr[7:4] == `DCP_BLK_CCS && regAddr[1:0] == 2'h0;
    assign cntSel  = regAddr[7:4] == `DCP_BLK_CNT && regAddr[1:0] == 2'h0;
    assign opSel   = regAddr == `DCP_OFF_OP;
    assign extFall = extS3_r & ~extS2_r & `DCP_EXT_CH_MASK;
    assign nmiRise = nmiS2_r & ~nmiS3_r;

    // halt terms are shared by all channels
    assign chanOk = chanEn_r & ~endFlag_r & {4{masterEn_r & ~nmiFlag_r & ~aeFlag_r}};

    always_comb begin
        for (int i = 0; i < `DCP_NCH; i++) begin
            live[i]    = chanOk[i] && (reqSrc_r[i] == `DCP_RS_AUTO || pend_r[i]);
            lastHit[i] = gntValid && gntCh == i[1:0] && xferCnt_r[i] <= 24'h00_0001;
        end
    end

    dcp_arbiter u_arb (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .reqVec   (live),
        .prioMode (prio_r),
        .gntValid (gntValid),
        .gntCh    (gntCh)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // channel state
    always_comb begin
        logic wrCh;
        logic rdCh;
        wrCh = 1'b0;
        rdCh = 1'b0;
        for (int i = 0; i < `DCP_NCH; i++) begin
            wrCh = regWr && ccsSel && chOf(regAddr) == i[1:0];
            rdCh = regRd && ccsSel && chOf(regAddr) == i[1:0];
            chanEn_nxt[i] = wrCh ? regWdata[`DCP_CCS_CE] : chanEn_r[i];
            irqEn_nxt[i]  = wrCh ? regWdata[`DCP_CCS_IE] : irqEn_r[i];
            reqSrc_nxt[i] = wrCh ? regWdata[`DCP_CCS_RS_HI:`DCP_CCS_RS_LO] : reqSrc_r[i];
            // a write of one leaves the flag alone; set wins over clear
            endFlag_nxt[i] = lastHit[i] || (endFlag_r[i] && !standbyEnter
                             && !(wrCh && endArm_r[i] && !regWdata[`DCP_CCS_TE]));
            endArm_nxt[i]  = wrCh ? 1'b0 : (endArm_r[i] || (rdCh && endFlag_r[i])) && endFlag_r[i];
            // requests count only while the channel may run
            pend_nxt[i] = chanOk[i] && !(gntValid && gntCh == i[1:0])
                          && (pend_r[i] || (reqSrc_r[i] == `DCP_RS_EXT && extFall[i])
                          || (reqSrc_r[i] == `DCP_RS_PERIPH && periphReq[i]));
            if (regWr && cntSel && chOf(regAddr) == i[1:0]) begin
                xferCnt_nxt[i] = regWdata[`DCP_CNT_W-1:0];
            end else if (gntValid && gntCh == i[1:0] && xferCnt_r[i] != `DCP_CNT_RST) begin
                xferCnt_nxt[i] = xferCnt_r[i] - 24'h00_0001;
            end else begin
                xferCnt_nxt[i] = xferCnt_r[i];
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chanEn_r  <= 4'h0;
            endFlag_r <= 4'h0;
            irqEn_r   <= 4'h0;
            endArm_r  <= 4'h0;
            pend_r    <= 4'h0;
            for (int i = 0; i < `DCP_NCH; i++) begin
                reqSrc_r[i]  <= `DCP_RS_RST;
                xferCnt_r[i] <= `DCP_CNT_RST;
            end
        end else begin
            chanEn_r  <= chanEn_nxt;
            endFlag_r <= endFlag_nxt;
            irqEn_r   <= irqEn_nxt;
            endArm_r  <= endArm_nxt;
            pend_r    <= pend_nxt;
            for (int i = 0; i < `DCP_NCH; i++) begin
                reqSrc_r[i]  <= reqSrc_nxt[i];
                xferCnt_r[i] <= xferCnt_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // operation register
    always_comb begin
        logic wrOp;
        logic rdOp;
        wrOp         = regWr && opSel;
        rdOp         = regRd && opSel;
        masterEn_nxt = wrOp ? regWdata[`DCP_OP_ME] : masterEn_r;
        prio_nxt     = wrOp ? dcp_prio_t'(regWdata[`DCP_OP_PR_HI:`DCP_OP_PR_LO]) : prio_r;
        // flags clear only on zero written after a one was read
        aeFlag_nxt  = addrErr || (aeFlag_r && !(wrOp && aeArm_r && !regWdata[`DCP_OP_AE]));
        nmiFlag_nxt = nmiRise || (nmiFlag_r && !(wrOp && nmiArm_r && !regWdata[`DCP_OP_NONMASKABLE_EVENT_FLAG]));
        aeArm_nxt   = wrOp ? 1'b0 : (aeArm_r || rdOp) && aeFlag_r;
        nmiArm_nxt  = wrOp ? 1'b0 : (nmiArm_r || rdOp) && nmiFlag_r;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            masterEn_r <= 1'b0;
            prio_r     <= PRIO_LINEAR;
            aeFlag_r   <= 1'b0;
            nmiFlag_r  <= 1'b0;
            aeArm_r    <= 1'b0;
            nmiArm_r   <= 1'b0;
        end else begin
            masterEn_r <= masterEn_nxt;
            prio_r     <= prio_nxt;
            aeFlag_r   <= aeFlag_nxt;
            nmiFlag_r  <= nmiFlag_nxt;
            aeArm_r    <= aeArm_nxt;
            nmiArm_r   <= nmiArm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data, valid only in the cycle after the strobe
    always_comb begin
        rdata_nxt = `DCP_RDATA_RST;
        if (regRd && ccsSel) begin
            rdata_nxt[`DCP_CCS_CE] = chanEn_r[chOf(regAddr)];
            rdata_nxt[`DCP_CCS_TE] = endFlag_r[chOf(regAddr)];
            rdata_nxt[`DCP_CCS_IE] = irqEn_r[chOf(regAddr)];
            rdata_nxt[`DCP_CCS_RS_HI:`DCP_CCS_RS_LO] = reqSrc_r[chOf(regAddr)];
        end else if (regRd && cntSel) begin
            rdata_nxt[`DCP_CNT_W-1:0] = xferCnt_r[chOf(regAddr)];
        end else if (regRd && opSel) begin
            // reserved bits stay at their zero default
            rdata_nxt[`DCP_OP_ME]   = masterEn_r;
            rdata_nxt[`DCP_OP_NONMASKABLE_EVENT_FLAG] = nmiFlag_r;
            rdata_nxt[`DCP_OP_AE]   = aeFlag_r;
            rdata_nxt[`DCP_OP_PR_HI:`DCP_OP_PR_LO] = prio_r;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r    <= `DCP_RDATA_RST;
            strobe_r   <= 1'b0;
            strobeCh_r <= 2'h0;
            chanOk_r   <= 4'h0;
            irq_r      <= 4'h0;
        end else begin
            rdata_r    <= rdata_nxt;
            strobe_r   <= gntValid;
            strobeCh_r <= gntCh;
            chanOk_r   <= chanOk;
            irq_r      <= endFlag_nxt & irqEn_nxt;
        end
    end

    // pins cross into core_clk before any edge detect looks at them
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            extS1_r <= 4'hF;
            extS2_r <= 4'hF;
            extS3_r <= 4'hF;
            nmiS1_r <= 1'b0;
            nmiS2_r <= 1'b0;
            nmiS3_r <= 1'b0;
        end else begin
            extS1_r <= extReqN;
            extS2_r <= extS1_r;
            extS3_r <= extS2_r;
            nmiS1_r <= nmiPin;
            nmiS2_r <= nmiS1_r;
            nmiS3_r <= nmiS2_r;
        end
    end

    assign regRdata    = rdata_r;
    assign xferStrobe  = strobe_r;
    assign xferCh      = strobeCh_r;
    assign chanEnabled = chanOk_r;
    assign irqReq      = irq_r;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_no_grant_end;
        gntValid |-> !endFlag_r[gntCh];
    endproperty
    a_no_grant_end: assert property (p_no_grant_end) else $error("grant on ended channel");

    property p_no_grant_off;
        gntValid |-> chanEn_r[gntCh] && masterEn_r;
    endproperty
    a_no_grant_off: assert property (p_no_grant_off) else $error("grant on disabled channel");

    property p_no_grant_halt;
        gntValid |-> !nmiFlag_r && !aeFlag_r;
    endproperty
    a_no_grant_halt: assert property (p_no_grant_halt) else $error("grant while halted");

    property p_ext_needs_req;
        gntValid && reqSrc_r[gntCh] != `DCP_RS_AUTO |-> pend_r[gntCh];
    endproperty
    a_ext_needs_req: assert property (p_ext_needs_req) else $error("grant without request");

    property p_strobe_follows;
        gntValid |=> xferStrobe && xferCh == $past(gntCh);
    endproperty
    a_strobe_follows: assert property (p_strobe_follows) else $error("strobe lost");

    property p_ae_set;
        addrErr |=> aeFlag_r ##1 (aeFlag_r || $past(aeArm_r));
    endproperty
    a_ae_set: assert property (p_ae_set) else $error("address error flag not set");

    property p_ae_clear;
        $fell(aeFlag_r) |-> $past(aeArm_r) && $past(regWr && opSel);
    endproperty
    a_ae_clear: assert property (p_ae_clear) else $error("address error flag cleared wrongly");

    property p_nmi_set;
        // chanEnabled is one cycle behind the flag, so it is looked at with the strobe
        nmiRise |=> nmiFlag_r ##1 (!chanEnabled[0] && !xferStrobe);
    endproperty
    a_nmi_set: assert property (p_nmi_set) else $error("nmi flag not set");

    property p_op_reserved;
        regRd && opSel |=> regRdata[31:10] == 22'h00_0000 && regRdata[7:3] == 5'h00;
    endproperty
    a_op_reserved: assert property (p_op_reserved) else $error("reserved bits not zero");

    for (genvar g = 0; g < `DCP_NCH; g++) begin : g_chk
        property p_end_on_last;
            lastHit[g] |=> endFlag_r[g];
        endproperty
        a_end_on_last: assert property (p_end_on_last) else $error("end flag missed");

        property p_end_cause;
            $rose(endFlag_r[g]) |-> $past(lastHit[g]);
        endproperty
        a_end_cause: assert property (p_end_cause) else $error("end flag set early");

        property p_irq_raise;
            lastHit[g] && irqEn_r[g] && !(regWr && ccsSel) |=> irqReq[g];
        endproperty
        a_irq_raise: assert property (p_irq_raise) else $error("completion irq missing");

        property p_auto_start;
            chanOk[g] && reqSrc_r[g] == `DCP_RS_AUTO && live == (4'h1 << g) |-> gntValid && gntCh == g;
        endproperty
        a_auto_start: assert property (p_auto_start) else $error("auto request not served");
    end

    c_end_flag: cover property ($rose(endFlag_r[0]));
    c_addr_err: cover property ($fell(aeFlag_r));
    c_ext_xfer: cover property (gntValid && reqSrc_r[gntCh] == `DCP_RS_EXT);

endmodule

//--- dcp_cfg.svh
// offsets, field positions, reset values and order tables of the channel control block
// assumes one 8-bit byte address per register port access, 32-bit words
`ifndef DCP_CFG_SVH
`define DCP_CFG_SVH

`define DCP_NCH          4
`define DCP_ADDR_W       8
`define DCP_CNT_W        24

// address map: four channel words, the operation word, four count words
`define DCP_BLK_CCS      4'h0
`define DCP_BLK_CNT      4'h2
`define DCP_OFF_OP       8'h10

// channel_control_status fields
`define DCP_CCS_CE       0
`define DCP_CCS_TE       1
`define DCP_CCS_IE       2
`define DCP_CCS_RS_LO    8
`define DCP_CCS_RS_HI    11

// controller_operation fields
`define DCP_OP_ME        0
`define DCP_OP_NONMASKABLE_EVENT_FLAG      1
`define DCP_OP_AE        2
`define DCP_OP_PR_LO     8
`define DCP_OP_PR_HI     9

// request_source_select codes
`define DCP_RS_EXT       4'h0
`define DCP_RS_AUTO      4'h4
`define DCP_RS_PERIPH    4'h8

// external request pins exist on channels 0 and 1 only
`define DCP_EXT_CH_MASK  4'h3

// reset values
`define DCP_RDATA_RST    32'h0000_0000
`define DCP_CNT_RST      24'h00_0000
`define DCP_RS_RST       4'h0
`define DCP_RR_LAST_RST  2'h3

// fixed orders, two bits per slot, slot 0 in the low bits
`define DCP_ORD_LIN      8'hE4
`define DCP_ORD_02       8'h78
`define DCP_ORD_20       8'hD2

`endif

//--- dcp_pkg.sv
// types shared by the channel control block and its arbiter
// assumes dcp_cfg.svh for all numeric constants
package dcp_pkg;

    typedef enum logic [1:0] {
        PRIO_LINEAR,
        PRIO_CH0_CH2,
        PRIO_CH2_FIRST,
        PRIO_ROUND
    } dcp_prio_t;

    typedef logic [3:0] dcp_chmask_t;

endpackage

//--- dcp_arbiter.sv
// channel arbiter: fixed orders and round robin
// assumes the caller accepts every grant in the cycle it is offered
`include "dcp_cfg.svh"

module dcp_arbiter import dcp_pkg::*; (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // requests and mode
    input  wire dcp_chmask_t reqVec,
    input  wire dcp_prio_t   prioMode,
    // grant
    output logic             gntValid,
    output logic [1:0]       gntCh
);

    logic [1:0] rrLast_r;
    logic [1:0] rrLast_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] slotCh(input dcp_prio_t m, input logic [1:0] base, input logic [1:0] k);
        logic [7:0] ord;
        ord = `DCP_ORD_LIN;
        unique case (m)
            PRIO_LINEAR:    ord = `DCP_ORD_LIN;
            PRIO_CH0_CH2:   ord = `DCP_ORD_02;
            PRIO_CH2_FIRST: ord = `DCP_ORD_20;
            PRIO_ROUND:     ord = `DCP_ORD_LIN;
        endcase
        if (m == PRIO_ROUND) begin
            slotCh = base + k;
        end else begin
            slotCh = ord[2 * k +: 2];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [1:0] c;
        c          = 2'h0;
        gntValid   = 1'b0;
        gntCh      = 2'h0;
        for (int k = 0; k < `DCP_NCH; k++) begin
            c = slotCh(prioMode, rrLast_r + 2'h1, k[1:0]);
            if (!gntValid && reqVec[c]) begin
                gntValid = 1'b1;
                gntCh    = c;
            end
        end
        // served channel drops to the last slot
        rrLast_nxt = gntValid ? gntCh : rrLast_r;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rrLast_r <= `DCP_RR_LAST_RST;
        end else begin
            rrLast_r <= rrLast_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_lin_ch0;
        gntValid && prioMode == PRIO_LINEAR && reqVec[0] |-> gntCh == 2'h0;
    endproperty
    a_lin_ch0: assert property (p_lin_ch0) else $error("linear order did not pick channel 0");

    property p_ch2_first;
        gntValid && prioMode == PRIO_CH2_FIRST && reqVec[2] |-> gntCh == 2'h2;
    endproperty
    a_ch2_first: assert property (p_ch2_first) else $error("channel 2 not first");

    property p_ch02_tail;
        gntValid && prioMode == PRIO_CH0_CH2 && reqVec == 4'hA |-> gntCh == 2'h3;
    endproperty
    a_ch02_tail: assert property (p_ch02_tail) else $error("channel 3 must beat channel 1");

    property p_rr_rotate;
        (gntValid && prioMode == PRIO_ROUND) ##1 (prioMode == PRIO_ROUND && reqVec == 4'hF)
            |-> gntCh == $past(gntCh) + 2'h1;
    endproperty
    a_rr_rotate: assert property (p_rr_rotate) else $error("round robin did not rotate");

    c_rr_rotate: cover property (p_rr_rotate);

endmodule

//--- dcp_req_model.sv
// far-side model: external request pins, peripheral request pulses, bus faults and the event pin
// assumes one core_clk; the bench calls the tasks below by hierarchical name
module dcp_req_model (
    // clock
    input  wire logic core_clk,
    // request and event lines toward the block
    output logic [3:0] extReqN,
    output logic [3:0] periphReq,
    output logic       nmiPin,
    output logic       addrErr
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        extReqN   = 4'hF;
        periphReq = 4'h0;
        nmiPin    = 1'b0;
        addrErr   = 1'b0;
    end

    // pins idle high on their pull-up; held low long enough for the two-stage synchroniser
    task automatic ext_pulse(input int ch);
        @(posedge core_clk);
        extReqN[ch] <= 1'b0;
        repeat (4) @(posedge core_clk);
        extReqN[ch] <= 1'b1;
    endtask

    task automatic periph_pulse(input int ch);
        @(posedge core_clk);
        periphReq[ch] <= 1'b1;
        @(posedge core_clk);
        periphReq[ch] <= 1'b0;
    endtask

    task automatic addr_fault();
        @(posedge core_clk);
        addrErr <= 1'b1;
        @(posedge core_clk);
        addrErr <= 1'b0;
    endtask

    task automatic nmi_event();
        @(posedge core_clk);
        nmiPin <= 1'b1;
        repeat (4) @(posedge core_clk);
        nmiPin <= 1'b0;
    endtask
endmodule

//--- dcp_channel_ctrl_bench.sv
// self-checking bench of the channel control block: register tasks, strobe capture, scenarios
// assumes dcp_req_model on the request side and the register map of dcp_cfg.svh
`include "dcp_cfg.svh"

module dcp_channel_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        standbyEnter = 1'b0;
    logic [31:0] regRdata;
    logic [3:0]  extReqN, periphReq, chanEnabled, irqReq;
    logic        nmiPin, addrErr, xferStrobe;
    logic [1:0]  xferCh;
    logic [1:0]  seenCh[$];
    int          badCount = 0;
    int          nChecks = 0;

    always #4 core_clk = ~core_clk;

    dcp_req_model REQ (.core_clk(core_clk), .extReqN(extReqN), .periphReq(periphReq),
                       .nmiPin(nmiPin), .addrErr(addrErr));

    dcp_channel_ctrl DUT (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
                          .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extReqN(extReqN),
                          .periphReq(periphReq), .nmiPin(nmiPin), .addrErr(addrErr),
                          .standbyEnter(standbyEnter), .xferStrobe(xferStrobe), .xferCh(xferCh),
                          .chanEnabled(chanEnabled), .irqReq(irqReq));

    // the strobe stands one cycle per transfer and stays high over back-to-back transfers, so every edge is looked at
    always @(posedge core_clk) begin
        if (xferStrobe === 1'b1) begin
            seenCh.push_back(xferCh);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        chk(what, regRdata, exp);
    endtask

    task automatic wait_strobes(input int n);
        for (int k = 0; k < 200 && seenCh.size() < n; k++) begin
            @(posedge core_clk);
        end
        if (seenCh.size() < n) begin
            badCount++;
            $display("CHECK FAILED strobe count expected %0d seen %0d", n, seenCh.size());
            tally_and_finish();
        end
    endtask

    task automatic quiet(input string what);
        repeat (6) @(posedge core_clk);
        seenCh.delete();
        repeat (20) @(posedge core_clk);
        chk(what, seenCh.size(), 0);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        badCount++;
        $display("CHECK FAILED run time limit expected end seen hang");
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0] modes[4] = '{2'h3, 2'h0, 2'h1, 2'h2};
        logic [7:0] ords[4] = '{`DCP_ORD_LIN, `DCP_ORD_LIN, `DCP_ORD_02, `DCP_ORD_20};
        int         s;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            rd_chk("status reset", 8'(c * 4), 32'h0);
        end
        rd_chk("operation reset", `DCP_OFF_OP, 32'h0);
        wr(`DCP_OFF_OP, 32'hFFFF_FFFF);
        rd_chk("operation reserved", `DCP_OFF_OP, 32'h0000_0301);
        wr(8'h40, 32'h0000_0001);
        rd_chk("unmapped", 8'h40, 32'h0);
        rd_chk("unaligned", 8'h13, 32'h0);
        $display("test registers done");

        // all four channels armed with master off so they request in the same cycle
        for (int m = 0; m < 4; m++) begin
            wr(`DCP_OFF_OP, {22'h0, modes[m], 8'h00});
            for (int c = 0; c < 4; c++) begin
                wr(8'(8'h20 + c * 4), 32'h2);
                wr(8'(c * 4), 32'h0000_0401);
            end
            seenCh.delete();
            wr(`DCP_OFF_OP, {22'h0, modes[m], 8'h01});
            wait_strobes(8);
            for (int i = 0; i < 8; i++) begin
                s = (modes[m] == 2'h3) ? i % 4 : i / 2;
                chk("grant order", seenCh[i], ords[m][s*2 +: 2]);
            end
            quiet("strobes after end");
            chk("enabled after end", chanEnabled, 32'h0);
            for (int c = 0; c < 4; c++) begin
                rd_chk("end flag set", 8'(c * 4), 32'h0000_0403);
                wr(8'(c * 4), 32'h0000_0400);
                rd_chk("end flag cleared", 8'(c * 4), 32'h0000_0400);
            end
        end
        rd_chk("count used up", 8'h20, 32'h0);
        $display("test priority done");

        wr(8'h00, 32'h0000_0405);
        seenCh.delete();
        wait_strobes(1);
        #1;
        chk("irq raised", irqReq, 32'h1);
        rd_chk("end and irq enable", 8'h00, 32'h0000_0407);
        wr(8'h00, 32'h0000_0407);
        wr(8'h00, 32'h0000_0404);
        rd_chk("end flag unarmed clear", 8'h00, 32'h0000_0406);
        @(posedge core_clk);
        standbyEnter <= 1'b1;
        @(posedge core_clk);
        standbyEnter <= 1'b0;
        rd_chk("end flag standby", 8'h00, 32'h0000_0404);
        chk("irq dropped", irqReq, 32'h0);
        $display("test completion done");

        wr(8'h24, 32'h100);
        wr(8'h04, 32'h0000_0405);
        seenCh.delete();
        wait_strobes(2);
        chk("channel enabled", chanEnabled, 32'h2);
        REQ.addr_fault();
        quiet("address error halt");
        wr(`DCP_OFF_OP, 32'h0000_0001);
        rd_chk("error flag kept", `DCP_OFF_OP, 32'h0000_0005);
        wr(`DCP_OFF_OP, 32'h0000_0001);
        rd_chk("error flag cleared", `DCP_OFF_OP, 32'h0000_0001);
        seenCh.delete();
        wait_strobes(1);
        wr(8'h04, 32'h0000_0404);
        quiet("channel disable halt");
        rd_chk("end flag after disable", 8'h04, 32'h0000_0404);
        wr(8'h04, 32'h0000_0405);
        seenCh.delete();
        wait_strobes(1);
        REQ.nmi_event();
        quiet("event halt");
        rd_chk("event flag", `DCP_OFF_OP, 32'h0000_0003);
        wr(`DCP_OFF_OP, 32'h0000_0000);
        quiet("master off halt");
        rd_chk("event flag cleared", `DCP_OFF_OP, 32'h0);
        rd_chk("end flag after abort", 8'h04, 32'h0000_0405);
        wr(8'h04, 32'h0000_0404);
        $display("test abort done");

        wr(`DCP_OFF_OP, 32'h0000_0001);
        wr(8'h20, 32'h1);
        REQ.ext_pulse(0);
        wr(8'h00, 32'h0000_0001);
        quiet("request before enable");
        REQ.ext_pulse(0);
        wait_strobes(1);
        chk("external channel", seenCh[0], 32'h0);
        wr(8'h28, 32'h1);
        wr(8'h08, 32'h0000_0801);
        seenCh.delete();
        REQ.periph_pulse(2);
        wait_strobes(1);
        chk("peripheral channel", seenCh[0], 32'h2);
        $display("test request sources done");
        tally_and_finish();
    end
endmodule
